/* tbc_regs.svh */
/*
 Register offsets, field positions, reset values and sizes of the
 trigger and break controller.
 Assumes it is included by its bare name from the design file.
*/
`ifndef TBC_REGS_SVH
`define TBC_REGS_SVH
`define TBC_ADDR_CTRL 3'h0
`define TBC_ADDR_TRIG 3'h1
`define TBC_ADDR_STAT 3'h2
`define TBC_ADDR_HEADL 3'h3
`define TBC_ADDR_HEADH 3'h4
`define TBC_CTRL_EN 7
`define TBC_CTRL_ARM 6
`define TBC_CTRL_TAG 5
`define TBC_CTRL_BRK 4
`define TBC_TRIG_SEL 7
`define TBC_TRIG_BEGIN 6
`define TBC_STAT_ARMED_FLAG 7
`define TBC_STAT_AF 6
`define TBC_STAT_BF 5
`define TBC_STAT_CF 4
`define TBC_CTRL_MASK 8'hF0
`define TBC_TRIG_MASK 8'hCF
`define TBC_CTRL_RST 8'h00
`define TBC_TRIG_RST 8'h00
`define TBC_FIFO_DEPTH 4'h8
`endif

/* tbc_pkg.sv */
/*
 Types of the trigger and break controller: trigger modes and the
 run state machine.
 Assumes nothing of its surroundings.
*/
package tbc_pkg;
  typedef enum logic [3:0] {
    TBC_A_ONLY = 4'h0,
    TBC_A_OR_B = 4'h1,
    TBC_A_THEN_B = 4'h2,
    TBC_EVT_B = 4'h3,
    TBC_A_THEN_EVT_B = 4'h4,
    TBC_A_AND_B = 4'h5,
    TBC_A_AND_NOT_B = 4'h6,
    TBC_INSIDE = 4'h7,
    TBC_OUTSIDE = 4'h8
  } tbc_mode_t;
  typedef enum logic [3:0] {
    TBC_ST_IDLE = 4'b0001,
    TBC_ST_END = 4'b0010,
    TBC_ST_WAIT = 4'b0100,
    TBC_ST_FILL = 4'b1000
  } tbc_state_t;
endpackage

/* tbc_trigger_break_controller.sv */
/*
 Trigger and break controller of the on-chip debug module: match flags,
 trigger modes, opcode tracking, trace run control, 8-entry trace FIFO
 and CPU break requests.
 Assumes comparator matches, bus and queue signals come from core logic
 on ref_clk, and a plain register port driven on the same clock.
*/
// The register offsets and the strobed register port are this design's own decisions.
// Notes on behaviour
// - Nothing breaks or captures unless the module enable bit is one.
// - Break enable gates all breaks; tag bit picks tag or force type.
// - Comparator C only breaks; it never triggers trace capture.
// - With qualify select set, A/B triggers wait for opcode execution; full, range and event B matches do not.
// - Comparators A and B each have their own opcode tracker; C has none.
// - End run: trigger stops capture; the match also drives break logic.
// - Begin run: trigger starts capture; break when the FIFO fills.
// - Begin run stores after the trigger until 8 entries are filled.
// - End run stores until trigger, oldest dropped beyond 8 entries.
// - Armed by enable and arm; arm alone clears at trigger or FIFO full, enable stays.
// - Any reset clears arm and armed flag, ending a run.
// - Armed flag clears on writing arm zero or enable low.
// - Arming clears the A, B, C flags; matches then set A/B flags.
// - FIFO holds change-of-flow addresses, or B-match data in events.
// - A-only sets A on A match; A-or-B sets whichever matched.
// - A-then-B ignores B until A matched; each match sets its flag.
// - Event-only modes run as begin type; A-then variant waits for A.
// - Full modes set both flags only on same-cycle A and B (or not B).
// - Tag breaks in full end runs use comparator A matches only.
// - Inside range sets both flags when A <= address <= B.
// - Force breaks at next boundary; tag breaks ride the queue.
// - Mode code 0x0 is A-only and 0x1 is A-or-B.
// - Outside range sets A below A, B above B.
`timescale 1ns/1ns
`include "tbc_regs.svh"
module tbc_trigger_break_controller (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic bus_cycle,
  input wire logic [7:0] bus_data,
  input wire logic cmp_a_match,
  input wire logic cmp_b_match,
  input wire logic cmp_c_match,
  input wire logic addr_ge_a,
  input wire logic addr_le_b,
  input wire logic opcode_fetch,
  input wire logic [1:0] queue_depth,
  input wire logic insn_start,
  input wire logic queue_flush,
  input wire logic cof_valid,
  input wire logic [15:0] cof_addr,
  output logic break_force_req,
  output logic break_tag_req,
  output logic [15:0] fifo_head,
  output logic capture_active
);
  function automatic logic tbc_is_event(input tbc_pkg::tbc_mode_t m);
    tbc_is_event = (m == tbc_pkg::TBC_EVT_B) ||
                   (m == tbc_pkg::TBC_A_THEN_EVT_B);
  endfunction
  function automatic logic tbc_is_full(input tbc_pkg::tbc_mode_t m);
    tbc_is_full = (m == tbc_pkg::TBC_A_AND_B) ||
                  (m == tbc_pkg::TBC_A_AND_NOT_B);
  endfunction

  logic [7:0] ctrl, next_ctrl;
  logic [7:0] trig, next_trig;
  logic flag_a, flag_b, flag_c, next_flag_a, next_flag_b, next_flag_c;
  logic a_seen, next_a_seen;
  logic [2:0] wr_ptr, next_wr_ptr;
  logic [3:0] count, next_count;
  logic brk_force, brk_tag, next_brk_force, next_brk_tag;
  logic [7:0] next_rdata;
  logic [15:0] next_head;
  logic [15:0] mem [0:7];
  tbc_pkg::tbc_state_t state, next_state;
  tbc_pkg::tbc_mode_t mode;
  logic ma, mb, mc, qa, qb, set_a, set_b, trig_hit, live, armed_bits;
  logic arm_start, begin_eff, evt, cap, cap_req, brk, tag_src;
  logic [15:0] cap_data;
  logic [1:0] trk;

  assign mode = tbc_pkg::tbc_mode_t'(trig[3:0]);
  assign ma = bus_cycle & cmp_a_match;
  assign mb = bus_cycle & cmp_b_match;
  assign mc = bus_cycle & cmp_c_match;
  assign evt = tbc_is_event(mode);
  // Trackers are separate so two compared opcodes can be in flight
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_trk
      logic pend, next_pend, hit, next_hit;
      logic [1:0] cnt, next_cnt;
      logic m;
      assign m = (gi == 0) ? ma : mb;
      always_comb begin
        next_pend = pend;
        next_cnt = cnt;
        next_hit = 1'b0;
        if (m && opcode_fetch) begin
          next_pend = 1'b1;
          next_cnt = queue_depth;
        end else if (queue_flush) begin
          next_pend = 1'b0;
        end else if (pend && insn_start) begin
          if (cnt == 2'h0) begin
            next_hit = 1'b1;
            next_pend = 1'b0;
          end else begin
            next_cnt = cnt - 2'h1;
          end
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          pend <= 1'b0;
          cnt <= 2'h0;
          hit <= 1'b0;
        end else begin
          pend <= next_pend;
          cnt <= next_cnt;
          hit <= next_hit;
        end
      end
      assign trk[gi] = hit;
    end
  endgenerate

  // Event modes compare B bare; the data match cannot be opcode tracked
  assign qa = trig[`TBC_TRIG_SEL] ? trk[0] : ma;
  assign qb = (trig[`TBC_TRIG_SEL] && !evt) ? trk[1] : mb;

  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    trig_hit = 1'b0;
    // Comparator C never enters this decision
    unique case (mode)
      tbc_pkg::TBC_A_ONLY: begin
        set_a = qa;
        trig_hit = qa;
      end
      tbc_pkg::TBC_A_OR_B: begin
        set_a = qa;
        set_b = qb;
        trig_hit = qa | qb;
      end
      tbc_pkg::TBC_A_THEN_B: begin
        set_a = qa;
        set_b = qb & a_seen;
        trig_hit = set_b;
      end
      tbc_pkg::TBC_EVT_B: begin
        set_b = mb;
        trig_hit = mb;
      end
      tbc_pkg::TBC_A_THEN_EVT_B: begin
        set_a = qa;
        set_b = mb & a_seen;
        trig_hit = set_b;
      end
      tbc_pkg::TBC_A_AND_B: begin
        set_a = ma & mb;
        set_b = ma & mb;
        trig_hit = ma & mb;
      end
      tbc_pkg::TBC_A_AND_NOT_B: begin
        set_a = ma & bus_cycle & !cmp_b_match;
        set_b = set_a;
        trig_hit = set_a;
      end
      tbc_pkg::TBC_INSIDE: begin
        set_a = bus_cycle & addr_ge_a & addr_le_b;
        set_b = set_a;
        trig_hit = set_a;
      end
      tbc_pkg::TBC_OUTSIDE: begin
        set_a = bus_cycle & !addr_ge_a;
        set_b = bus_cycle & !addr_le_b;
        trig_hit = set_a | set_b;
      end
      default: begin
        trig_hit = 1'b0;
      end
    endcase
  end

  assign armed_bits = ctrl[`TBC_CTRL_EN] & ctrl[`TBC_CTRL_ARM];
  assign live = (state != tbc_pkg::TBC_ST_IDLE);
  assign begin_eff = trig[`TBC_TRIG_BEGIN] | evt;
  assign arm_start = reg_wr && (reg_addr == `TBC_ADDR_CTRL) &&
                     reg_wdata[`TBC_CTRL_EN] && reg_wdata[`TBC_CTRL_ARM] &&
                     !armed_bits;
  assign cap_req = evt ? mb : cof_valid;
  assign cap_data = evt ? {8'h00, bus_data} : cof_addr;
  // Tag breaks are placed on the raw match in A-only, A-or-B and full modes, on the trigger elsewhere; the CPU queue times them
  assign tag_src = (mode == tbc_pkg::TBC_A_ONLY || tbc_is_full(mode)) ?
                   ma :
                   (mode == tbc_pkg::TBC_A_OR_B) ? (ma | mb) : trig_hit;

  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_trig = trig;
    next_flag_a = flag_a;
    next_flag_b = flag_b;
    next_flag_c = flag_c;
    next_a_seen = a_seen;
    next_wr_ptr = wr_ptr;
    next_count = count;
    cap = 1'b0;
    brk = 1'b0;
    if (arm_start) begin
      next_flag_a = 1'b0;
      next_flag_b = 1'b0;
      next_flag_c = 1'b0;
      next_a_seen = 1'b0;
      next_wr_ptr = 3'h0;
      next_count = 4'h0;
      next_state = begin_eff ? tbc_pkg::TBC_ST_WAIT : tbc_pkg::TBC_ST_END;
    end else if (!armed_bits) begin
      next_state = tbc_pkg::TBC_ST_IDLE;
    end else begin
      unique case (state)
        tbc_pkg::TBC_ST_IDLE: begin
          next_state = tbc_pkg::TBC_ST_IDLE;
        end
        tbc_pkg::TBC_ST_END: begin
          if (trig_hit) begin
            next_state = tbc_pkg::TBC_ST_IDLE;
            next_ctrl[`TBC_CTRL_ARM] = 1'b0;
          end else begin
            cap = cap_req;
          end
          brk = ctrl[`TBC_CTRL_TAG] ? tag_src : trig_hit;
        end
        tbc_pkg::TBC_ST_WAIT: begin
          if (trig_hit) begin
            next_state = tbc_pkg::TBC_ST_FILL;
          end
        end
        tbc_pkg::TBC_ST_FILL: begin
          // A full begin run takes nothing more; the oldest entry stays
          if (count == `TBC_FIFO_DEPTH) begin
            next_state = tbc_pkg::TBC_ST_IDLE;
            next_ctrl[`TBC_CTRL_ARM] = 1'b0;
            brk = 1'b1;
          end else begin
            cap = cap_req;
          end
        end
      endcase
    end
    if (cap && count != `TBC_FIFO_DEPTH) begin
      next_count = count + 4'h1;
    end
    if (cap) begin
      next_wr_ptr = wr_ptr + 3'h1;
    end
    // Sets are applied last so an event in an arming cycle is kept while the state is still live
    if (live) begin
      next_flag_a = next_flag_a | set_a;
      next_flag_b = next_flag_b | set_b;
      next_flag_c = next_flag_c | mc;
      next_a_seen = next_a_seen | set_a;
    end
    // Software write last; a rewrite of arm beats the hardware clear
    if (reg_wr && reg_addr == `TBC_ADDR_CTRL) begin
      next_ctrl = reg_wdata & `TBC_CTRL_MASK;
    end
    if (reg_wr && reg_addr == `TBC_ADDR_TRIG) begin
      next_trig = reg_wdata & `TBC_TRIG_MASK;
    end
    brk = (brk | mc) & ctrl[`TBC_CTRL_EN];
    next_brk_force = brk & ctrl[`TBC_CTRL_BRK] &
                     !ctrl[`TBC_CTRL_TAG];
    next_brk_tag = brk & ctrl[`TBC_CTRL_BRK] &
                   ctrl[`TBC_CTRL_TAG];
  end

  always_comb begin
    next_rdata = 8'h00;
    next_head = mem[wr_ptr - count[2:0]];
    if (count == 4'h0) begin
      next_head = 16'h0000;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `TBC_ADDR_CTRL: next_rdata = ctrl;
        `TBC_ADDR_TRIG: next_rdata = trig;
        `TBC_ADDR_STAT: next_rdata = {live, flag_a, flag_b, flag_c, count};
        `TBC_ADDR_HEADL: next_rdata = fifo_head[7:0];
        `TBC_ADDR_HEADH: next_rdata = fifo_head[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // The array is not reset; entries beyond count are never shown
  always_ff @(posedge ref_clk) begin
    if (cap) begin
      mem[wr_ptr] <= cap_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= tbc_pkg::TBC_ST_IDLE;
      ctrl <= `TBC_CTRL_RST;
      trig <= `TBC_TRIG_RST;
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      flag_c <= 1'b0;
      a_seen <= 1'b0;
      wr_ptr <= 3'h0;
      count <= 4'h0;
      brk_force <= 1'b0;
      brk_tag <= 1'b0;
      reg_rdata <= 8'h00;
      fifo_head <= 16'h0000;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      trig <= next_trig;
      flag_a <= next_flag_a;
      flag_b <= next_flag_b;
      flag_c <= next_flag_c;
      a_seen <= next_a_seen;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      brk_force <= next_brk_force;
      brk_tag <= next_brk_tag;
      reg_rdata <= next_rdata;
      fifo_head <= next_head;
    end
  end

  assign break_force_req = brk_force;
  assign break_tag_req = brk_tag;
  assign capture_active = (state == tbc_pkg::TBC_ST_END) ||
                          (state == tbc_pkg::TBC_ST_FILL);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence fill_last;
    state == tbc_pkg::TBC_ST_FILL && count == `TBC_FIFO_DEPTH &&
    armed_bits && !reg_wr;
  endsequence
  sequence run_over;
    state == tbc_pkg::TBC_ST_IDLE && !ctrl[`TBC_CTRL_ARM];
  endsequence

  en_gates_break_a: assert property (
    !ctrl[`TBC_CTRL_EN] |=> !break_force_req && !break_tag_req)
    else $error("break raised while module disabled");
  brk_type_a: assert property (
    break_tag_req |-> $past(ctrl[`TBC_CTRL_TAG]) &&
                      $past(ctrl[`TBC_CTRL_BRK]))
    else $error("tag break without tag and break enable");
  c_no_trig_a: assert property (
    state == tbc_pkg::TBC_ST_END && mode == tbc_pkg::TBC_A_OR_B &&
    cmp_c_match && !cmp_a_match && !cmp_b_match && trk == 2'b00 &&
    armed_bits && !reg_wr |=> state == tbc_pkg::TBC_ST_END)
    else $error("comparator C ended a trace run");
  qual_wait_a: assert property (
    live && trig[`TBC_TRIG_SEL] && mode == tbc_pkg::TBC_A_ONLY &&
    ma && !trk[0] && !arm_start |=> flag_a == $past(flag_a))
    else $error("unqualified A match set the flag");
  end_stop_a: assert property (
    state == tbc_pkg::TBC_ST_END && trig_hit && armed_bits && !reg_wr
    |=> run_over)
    else $error("end trigger did not stop the run");
  begin_start_a: assert property (
    state == tbc_pkg::TBC_ST_WAIT && trig_hit && armed_bits && !reg_wr
    |=> state == tbc_pkg::TBC_ST_FILL)
    else $error("begin trigger did not start capture");
  fill_break_a: assert property (
    fill_last |=> run_over ##0
    (break_force_req | break_tag_req) == $past(ctrl[`TBC_CTRL_BRK]))
    else $error("full FIFO did not end the run or break");
  end_wrap_a: assert property (
    state == tbc_pkg::TBC_ST_END && count == `TBC_FIFO_DEPTH && cap
    |=> count == `TBC_FIFO_DEPTH && wr_ptr == $past(wr_ptr) + 3'h1)
    else $error("end run FIFO did not wrap");
  armed_flag_low_a: assert property (
    !armed_bits && !arm_start |=> !live)
    else $error("armed flag stayed without enable and arm");
  arm_clear_a: assert property (
    arm_start |=> live && (!flag_a || $past(live && set_a)) &&
    (!flag_b || $past(live && set_b)) && (!flag_c || $past(live && mc)))
    else $error("arming did not clear the flags");
  full_same_a: assert property (
    live && mode == tbc_pkg::TBC_A_AND_B && ma && !mb && !arm_start
    |=> flag_a == $past(flag_a) && flag_b == $past(flag_b))
    else $error("lone A match set a flag in full mode");
endmodule

/* tbc_core_model.sv */
/*
 Core-side model: bus cycles, comparator matches, opcode fetch and
 queue, change-of-flow events; counts break request pulses.
 Assumes the bench calls its tasks from ref_clk processes.
*/
`timescale 1ns/1ns
module tbc_core_model (
  input wire logic ref_clk,
  input wire logic break_force_req,
  input wire logic break_tag_req,
  output logic bus_cycle,
  output logic [7:0] bus_data,
  output logic cmp_a_match,
  output logic cmp_b_match,
  output logic cmp_c_match,
  output logic addr_ge_a,
  output logic addr_le_b,
  output logic opcode_fetch,
  output logic [1:0] queue_depth,
  output logic insn_start,
  output logic queue_flush,
  output logic cof_valid,
  output logic [15:0] cof_addr
);
  int n_force = 0;
  int n_tag = 0;
  logic [1:0] qd = 2'h0;
  initial begin
    {bus_cycle, cmp_a_match, cmp_b_match, cmp_c_match} = 4'h0;
    {addr_ge_a, addr_le_b, opcode_fetch, insn_start} = 4'h0;
    {queue_flush, cof_valid} = 2'h0;
    bus_data = 8'h00;
    queue_depth = 2'h0;
    cof_addr = 16'h0000;
  end
  always @(posedge ref_clk) begin
    if (break_force_req === 1'b1) n_force <= n_force + 1;
    if (break_tag_req === 1'b1) n_tag <= n_tag + 1;
  end
  task automatic clr();
    n_force = 0;
    n_tag = 0;
  endtask
  // Every match comes with an opcode fetch so trackers can load
  task automatic bus(input logic [2:0] m, input logic [1:0] r,
                     input logic [7:0] d);
    @(posedge ref_clk);
    bus_cycle <= 1'b1;
    {cmp_a_match, cmp_b_match, cmp_c_match} <= m;
    {addr_ge_a, addr_le_b} <= r;
    bus_data <= d;
    opcode_fetch <= 1'b1;
    queue_depth <= qd;
    @(posedge ref_clk);
    bus_cycle <= 1'b0;
    {cmp_a_match, cmp_b_match, cmp_c_match} <= 3'h0;
    opcode_fetch <= 1'b0;
    // Idle lines show junk, not the last value
    {addr_ge_a, addr_le_b} <= ~r;
    bus_data <= ~d;
  endtask
  task automatic cof(input logic [15:0] a);
    @(posedge ref_clk);
    cof_valid <= 1'b1;
    cof_addr <= a;
    @(posedge ref_clk);
    cof_valid <= 1'b0;
    cof_addr <= ~a;
  endtask
  // Drops whatever the trackers still hold from earlier matches
  task automatic flush();
    @(posedge ref_clk);
    queue_flush <= 1'b1;
    @(posedge ref_clk);
    queue_flush <= 1'b0;
  endtask
  task automatic insn();
    @(posedge ref_clk);
    insn_start <= 1'b1;
    @(posedge ref_clk);
    insn_start <= 1'b0;
  endtask
endmodule

/* tbc_trigger_break_controller_test.sv */
/*
 Self-checking bench of the trigger and break controller.
 Assumes the core model drives the bus side; registers via plain port.
*/
`timescale 1ns/1ns
module tbc_trigger_break_controller_test;
  logic ref_clk;
  logic reset_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  wire logic bus_cycle, cmp_a_match, cmp_b_match, cmp_c_match;
  wire logic addr_ge_a, addr_le_b, opcode_fetch, insn_start;
  wire logic queue_flush, cof_valid;
  wire logic [7:0] bus_data;
  wire logic [1:0] queue_depth;
  wire logic [15:0] cof_addr;
  logic break_force_req, break_tag_req, capture_active;
  logic [15:0] fifo_head;
  logic [7:0] v, w;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  tbc_trigger_break_controller dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_cycle(bus_cycle),
    .bus_data(bus_data), .cmp_a_match(cmp_a_match),
    .cmp_b_match(cmp_b_match), .cmp_c_match(cmp_c_match),
    .addr_ge_a(addr_ge_a), .addr_le_b(addr_le_b),
    .opcode_fetch(opcode_fetch), .queue_depth(queue_depth),
    .insn_start(insn_start), .queue_flush(queue_flush),
    .cof_valid(cof_valid), .cof_addr(cof_addr),
    .break_force_req(break_force_req), .break_tag_req(break_tag_req),
    .fifo_head(fifo_head), .capture_active(capture_active));
  tbc_core_model core (.ref_clk(ref_clk),
    .break_force_req(break_force_req), .break_tag_req(break_tag_req),
    .bus_cycle(bus_cycle), .bus_data(bus_data),
    .cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match),
    .cmp_c_match(cmp_c_match), .addr_ge_a(addr_ge_a),
    .addr_le_b(addr_le_b), .opcode_fetch(opcode_fetch),
    .queue_depth(queue_depth), .insn_start(insn_start),
    .queue_flush(queue_flush), .cof_valid(cof_valid),
    .cof_addr(cof_addr));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Leading gap lets flags and tracker pulses of the last event land
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    repeat (3) @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(16'(d), 16'(e));
  endtask
  task automatic cs(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(3'h2, d);
    check(16'(d & m), 16'(e));
  endtask
  // Disarm first so the control write is a fresh arming
  task automatic arm(input logic [7:0] t, input logic [7:0] c);
    wr(3'h0, 8'h00);
    wr(3'h1, t);
    wr(3'h0, c);
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic mode_case(input logic [7:0] t, input logic [2:0] m,
                           input logic [1:0] r, input logic [7:0] e);
    arm(t, 8'hC0);
    core.bus(m, r, 8'h00);
    cs(8'h60, e);
  endtask
  initial begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc(3'h0, 8'h00);
    rc(3'h1, 8'h00);
    cs(8'hFF, 8'h00);
    wr(3'h5, 8'hFF);
    rc(3'h5, 8'h00);
    core.clr();
    arm(8'h00, 8'h50);
    core.bus(3'b101, 2'h0, 8'h00);
    cs(8'hFF, 8'h00);
    check(16'(core.n_force), 16'h0000);
    check(16'(capture_active), 16'h0000);
    core.clr();
    arm(8'h01, 8'hD0);
    check(16'(capture_active), 16'h0001);
    core.bus(3'b010, 2'h0, 8'h00);
    cs(8'hFF, 8'h20);
    rc(3'h0, 8'h90);
    check(16'(core.n_force), 16'h0001);
    check(16'(capture_active), 16'h0000);
    core.clr();
    core.flush();
    core.qd = 2'h1;
    arm(8'h81, 8'hF0);
    core.bus(3'b100, 2'h0, 8'h00);
    cs(8'hFF, 8'h80);
    check(16'(core.n_tag), 16'h0001);
    core.insn();
    cs(8'hFF, 8'h80);
    core.insn();
    cs(8'hE0, 8'h40);
    check(16'(core.n_tag), 16'h0001);
    check(16'(core.n_force), 16'h0000);
    core.qd = 2'h0;
    core.clr();
    arm(8'h40, 8'hD0);
    core.cof(16'h1111);
    cs(8'h0F, 8'h00);
    core.bus(3'b100, 2'h0, 8'h00);
    for (int i = 0; i < 8; i++) core.cof(16'h2000 + 16'(i));
    cs(8'hFF, 8'h48);
    check(16'(core.n_force), 16'h0001);
    check(fifo_head, 16'h2000);
    core.clr();
    arm(8'h00, 8'hC0);
    for (int i = 0; i < 10; i++) core.cof(16'h3000 + 16'(i));
    cs(8'hFF, 8'h88);
    check(fifo_head, 16'h3002);
    rc(3'h3, 8'h02);
    rc(3'h4, 8'h30);
    core.bus(3'b100, 2'h0, 8'h00);
    core.cof(16'h4000);
    cs(8'hFF, 8'h48);
    check(fifo_head, 16'h3002);
    check(16'(core.n_force), 16'h0000);
    core.clr();
    arm(8'h01, 8'hD0);
    core.bus(3'b001, 2'h0, 8'h00);
    cs(8'hF0, 8'h90);
    check(16'(core.n_force), 16'h0001);
    wr(3'h0, 8'h80);
    cs(8'h80, 8'h00);
    core.clr();
    arm(8'h05, 8'hF0);
    core.bus(3'b100, 2'h0, 8'h00);
    cs(8'h60, 8'h00);
    check(16'(core.n_tag), 16'h0001);
    arm(8'h02, 8'hC0);
    core.bus(3'b010, 2'h0, 8'h00);
    cs(8'hE0, 8'h80);
    core.bus(3'b100, 2'h0, 8'h00);
    cs(8'hE0, 8'hC0);
    core.bus(3'b010, 2'h0, 8'h00);
    cs(8'hE0, 8'h60);
    mode_case(8'h05, 3'b100, 2'h0, 8'h00);
    mode_case(8'h05, 3'b110, 2'h0, 8'h60);
    mode_case(8'h06, 3'b110, 2'h0, 8'h00);
    mode_case(8'h06, 3'b100, 2'h0, 8'h60);
    mode_case(8'h00, 3'b010, 2'h0, 8'h00);
    mode_case(8'h07, 3'b000, 2'h2, 8'h00);
    mode_case(8'h07, 3'b000, 2'h3, 8'h60);
    mode_case(8'h08, 3'b000, 2'h1, 8'h40);
    arm(8'h03, 8'hC0);
    check(16'(capture_active), 16'h0000);
    core.bus(3'b010, 2'h0, 8'h5A);
    cs(8'hE0, 8'hA0);
    check(16'(capture_active), 16'h0001);
    rd(3'h2, v);
    core.cof(16'h5555);
    core.bus(3'b010, 2'h0, 8'hA5);
    rd(3'h2, w);
    check(16'(w[3:0]), 16'(v[3:0] + 4'h1));
    check(fifo_head, 16'h00A5);
    arm(8'h00, 8'hC0);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc(3'h0, 8'h00);
    cs(8'hFF, 8'h00);
    conclude();
  end
endmodule
